// ===== logic/fod_consts.vh
// Constants for the flag and operand decode block
`ifndef FOD_CONSTS_VH
`define FOD_CONSTS_VH
// Status flag bit positions
`define FOD_FLAG_SIGN       7
`define FOD_FLAG_ZERO       6
`define FOD_FLAG_HALF       4
`define FOD_FLAG_PV         2
`define FOD_FLAG_SUB        1
`define FOD_FLAG_CARRY      0
`define FOD_FLAG_RESET      8'h00
`define FOD_FLAG_DEF_MASK   8'hD7
// Register offsets (word indexes)
`define FOD_ADR_FLAGS       4'h0
`define FOD_ADR_REGA        4'h1
`define FOD_ADR_REGBC       4'h2
`define FOD_ADR_REGDE       4'h3
`define FOD_ADR_REGHL       4'h4
`define FOD_ADR_REGIX       4'h5
`define FOD_ADR_REGIY       4'h6
`define FOD_ADR_REGSP       4'h7
`define FOD_ADR_REGPC       4'h8
`define FOD_ADR_ALU         4'h9
`define FOD_ADR_ALURES      4'hA
`define FOD_ADR_SEL         4'hB
`define FOD_ADR_ADDR        4'hC
`define FOD_ADR_IO          4'hD
`define FOD_ADR_OPERAND     4'hE
// ALU operation codes
`define FOD_OP_ADD          4'h0
`define FOD_OP_ADC          4'h1
`define FOD_OP_SUB          4'h2
`define FOD_OP_SBC          4'h3
`define FOD_OP_CP           4'h4
`define FOD_OP_INC          4'h5
`define FOD_OP_DEC          4'h6
`define FOD_OP_AND          4'h7
`define FOD_OP_OR           4'h8
`define FOD_OP_XOR          4'h9
`define FOD_OP_RLCA         4'hA
`define FOD_OP_RRCA         4'hB
`define FOD_OP_ADD16        4'hC
`define FOD_OP_SBC16        4'hD
`define FOD_OP_LOADF        4'hE
// Addressing modes
`define FOD_AM_INDIRECT     3'h0
`define FOD_AM_INDEXED      3'h1
`define FOD_AM_EXTENDED     3'h2
`define FOD_AM_IMMEDIATE    3'h3
`define FOD_AM_RELATIVE     3'h4
// Pair field types
`define FOD_PT_HL           2'h0
`define FOD_PT_INDEX1       2'h1
`define FOD_PT_INDEX2       2'h2
`define FOD_PT_PUSHPOP      2'h3
// I/O address forms
`define FOD_IO_IMM_ACC      2'h0
`define FOD_IO_BC           2'h1
`define FOD_IO_IMM_INT      2'h2
`define FOD_IO_C_INT        2'h3
`define FOD_IO_HOLD         8'h04
`define FOD_ZERO_BYTE       8'h00
`endif

// ===== logic/fod_flags_decode.v
// Flag generation, register select decode and operand address forming
// Software loads registers over the bus, then issues an ALU, select or
// I/O command by writing its command index. Results are read back from
// their own indexes. One I/O command pulls the request strobe low for
// IO_HOLD cycles with the formed address held on the bus.
`timescale 1ns/10ps
`include "fod_consts.vh"
module fod_flags_decode #(
   // Low cycles of the request strobe for each I/O command
   parameter IO_HOLD = `FOD_IO_HOLD
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire [3:0]  wb_adr_i,
   input  wire [31:0] wb_dat_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_sel_i,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg  [15:0] io_addr,
   output reg         io_request_strobe_n
);

   // Accumulator and status flags, the pair used by push and pop
   reg  [7:0]  status_flags_reg;
   reg  [7:0]  acc_reg;

   // General register pairs; B, D and H sit in bits 15:8
   reg  [15:0] bc_reg;
   reg  [15:0] de_reg;
   reg  [15:0] hl_reg;

   // Index registers, stack pointer and program counter
   reg  [15:0] index_reg_first;
   reg  [15:0] index_reg_second;
   reg  [15:0] sp_reg;
   reg  [15:0] pc_reg;

   // Results kept for software to read back
   reg  [15:0] alu_res_reg;
   reg  [15:0] op_addr_reg;
   reg  [15:0] operand_reg;

   // Cycles left in the current I/O request
   reg  [7:0]  io_cnt_reg;

   // Bus decode: a request is taken while no ack is out
   wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // A write lands on the edge that also sees ack, while the master still
   // holds address and data; only byte lane 0 enables a write
   wire        bus_wr   = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

   // Register loads use the low half word of the data bus
   wire [15:0] wdat     = wb_dat_i[15:0];

   // ALU command word: operation in bits 3:0, byte operand in 11:4 and
   // word operand in 31:16 for the HL add and subtract
   wire [3:0]  alu_op   = wb_dat_i[3:0];
   wire [7:0]  alu_b    = wb_dat_i[11:4];
   wire [15:0] alu_b16  = wb_dat_i[31:16];

   // Select word: byte field [2:0], pair field [4:3], pair type [6:5], high [7],
   //              mode [10:8], displacement/low byte [23:16], high byte [31:24]
   wire [2:0]  sel_byte = wb_dat_i[2:0];
   wire [1:0]  sel_pair = wb_dat_i[4:3];
   wire [1:0]  sel_type = wb_dat_i[6:5];
   wire        sel_high = wb_dat_i[7];
   wire [2:0]  sel_mode = wb_dat_i[10:8];

   // Instruction bytes; the low one doubles as the displacement
   wire [7:0]  byte_lo  = wb_dat_i[23:16];
   wire [7:0]  byte_hi  = wb_dat_i[31:24];

   // Byte register select; code 110 names no register, so it reads
   // as zero here rather than aliasing one
   reg  [7:0]  byte_val;
   always @* begin
      case (sel_byte)
         3'h0:    byte_val = bc_reg[15:8];
         3'h1:    byte_val = bc_reg[7:0];
         3'h2:    byte_val = de_reg[15:8];
         3'h3:    byte_val = de_reg[7:0];
         3'h4:    byte_val = hl_reg[15:8];
         3'h5:    byte_val = hl_reg[7:0];
         3'h7:    byte_val = acc_reg;
         default: byte_val = `FOD_ZERO_BYTE;    // Code 110 selects no register
      endcase
   end

   // Register pair select by field type; BC and DE are fixed codes,
   // the other two depend on which field the opcode carries
   reg  [15:0] pair_val;
   always @* begin
      case (sel_pair)
         2'h0:    pair_val = bc_reg;
         2'h1:    pair_val = de_reg;
         // Field type picks HL or one of the index registers
         2'h2: begin
            case (sel_type)
               `FOD_PT_INDEX1: pair_val = index_reg_first;
               `FOD_PT_INDEX2: pair_val = index_reg_second;
               default:    pair_val = hl_reg;
            endcase
         end
         // Stack pointer, or accumulator with flags for push and pop
         default: pair_val = (sel_type == `FOD_PT_PUSHPOP) ?
                             {acc_reg, status_flags_reg} : sp_reg;
      endcase
   end

   // High or low half of the selected pair
   wire [7:0]  half_val = sel_high ? pair_val[15:8] : pair_val[7:0];

   // Operand address forming. Indirect pair 11 has no stack meaning here
   // and falls back to HL. Displacements are sign extended before the
   // add, so a byte of 80 to FF steps backwards. Immediate and unused
   // mode codes leave the last address in place.
   reg  [15:0] addr_next;
   always @* begin
      case (sel_mode)
         `FOD_AM_INDIRECT:  addr_next = (sel_pair == 2'h3) ? hl_reg : pair_val;
         `FOD_AM_INDEXED:   addr_next = ((sel_type == `FOD_PT_INDEX2) ? index_reg_second :
                              index_reg_first) + {{8{byte_lo[7]}}, byte_lo};
         `FOD_AM_EXTENDED:  addr_next = {byte_hi, byte_lo};
         `FOD_AM_RELATIVE:  addr_next = pc_reg + {{8{byte_lo[7]}}, byte_lo};
         default:           addr_next = op_addr_reg;
      endcase
   end

   // Flag computation for the ALU command. Everything is worked out from
   // the command word on the bus and the current registers; the
   // accumulator itself is never changed. The working values below are
   // all given a value at the top of the process.
   reg  [7:0]  res8;
   reg  [15:0] res16;
   reg  [7:0]  flag_next;
   reg  [4:0]  nib;
   reg  [8:0]  wide;
   reg  [16:0] wide16;
   reg         cin;
   always @* begin
      res8      = 8'h00;
      res16     = 16'h0000;
      nib       = 5'h00;
      wide      = 9'h000;
      wide16    = 17'h00000;
      cin       = status_flags_reg[`FOD_FLAG_CARRY];
      flag_next = status_flags_reg;
      case (alu_op)
         // Add group: INC adds one through the carry input and keeps C
         `FOD_OP_ADD, `FOD_OP_ADC, `FOD_OP_INC: begin
            if (alu_op == `FOD_OP_ADD) cin = 1'b0;
            if (alu_op == `FOD_OP_INC) cin = 1'b1;
            nib  = {1'b0, acc_reg[3:0]} + {1'b0, (alu_op == `FOD_OP_INC) ? 4'h0 : alu_b[3:0]}
                   + {4'h0, cin};
            wide = {1'b0, acc_reg} + {1'b0, (alu_op == `FOD_OP_INC) ? 8'h00 : alu_b}
                   + {8'h00, cin};
            res8 = wide[7:0];
            flag_next[`FOD_FLAG_HALF] = nib[4];
            flag_next[`FOD_FLAG_PV]   = (acc_reg[7] == ((alu_op == `FOD_OP_INC) ? 1'b0 :
                                         alu_b[7])) && (res8[7] != acc_reg[7]);
            flag_next[`FOD_FLAG_SUB]  = 1'b0;
            if (alu_op != `FOD_OP_INC)
               flag_next[`FOD_FLAG_CARRY] = wide[8];
         end

         // Subtract group: DEC takes one off and keeps C; CP sets flags and result as SUB does
         `FOD_OP_SUB, `FOD_OP_SBC, `FOD_OP_CP, `FOD_OP_DEC: begin
            if (alu_op != `FOD_OP_SBC) cin = (alu_op == `FOD_OP_DEC);
            nib  = {1'b0, acc_reg[3:0]} - {1'b0, (alu_op == `FOD_OP_DEC) ? 4'h0 : alu_b[3:0]}
                   - {4'h0, cin};
            wide = {1'b0, acc_reg} - {1'b0, (alu_op == `FOD_OP_DEC) ? 8'h00 : alu_b}
                   - {8'h00, cin};
            res8 = wide[7:0];
            flag_next[`FOD_FLAG_HALF] = nib[4];
            flag_next[`FOD_FLAG_PV]   = (acc_reg[7] != ((alu_op == `FOD_OP_DEC) ? 1'b0 :
                                         alu_b[7])) && (res8[7] != acc_reg[7]);
            flag_next[`FOD_FLAG_SUB]  = 1'b1;
            if (alu_op != `FOD_OP_DEC)
               flag_next[`FOD_FLAG_CARRY] = wide[8];
         end

         // Logic group: AND sets H, OR and XOR clear it; N and C cleared
         `FOD_OP_AND, `FOD_OP_OR, `FOD_OP_XOR: begin
            res8 = (alu_op == `FOD_OP_AND) ? (acc_reg & alu_b) :
                   (alu_op == `FOD_OP_OR)  ? (acc_reg | alu_b) : (acc_reg ^ alu_b);
            flag_next[`FOD_FLAG_HALF]  = (alu_op == `FOD_OP_AND);
            flag_next[`FOD_FLAG_PV]    = ~^res8;
            flag_next[`FOD_FLAG_SUB]   = 1'b0;
            flag_next[`FOD_FLAG_CARRY] = 1'b0;
         end

         // Accumulator rotates touch only C, H and N
         `FOD_OP_RLCA, `FOD_OP_RRCA: begin
            res8 = (alu_op == `FOD_OP_RLCA) ? {acc_reg[6:0], acc_reg[7]} :
                                              {acc_reg[0], acc_reg[7:1]};
            flag_next[`FOD_FLAG_CARRY] = (alu_op == `FOD_OP_RLCA) ? acc_reg[7] :
                                                                    acc_reg[0];
            flag_next[`FOD_FLAG_HALF]  = 1'b0;
            flag_next[`FOD_FLAG_SUB]   = 1'b0;
         end

         // Word add and subtract on HL; H is left as it was
         `FOD_OP_ADD16, `FOD_OP_SBC16: begin
            cin    = (alu_op == `FOD_OP_SBC16) & status_flags_reg[`FOD_FLAG_CARRY];
            wide16 = (alu_op == `FOD_OP_ADD16) ?
                     ({1'b0, hl_reg} + {1'b0, alu_b16}) :
                     ({1'b0, hl_reg} - {1'b0, alu_b16} - {16'h0000, cin});
            res16  = wide16[15:0];
            res8   = res16[15:8];
            flag_next[`FOD_FLAG_PV]    = (alu_op == `FOD_OP_ADD16) ?
               ((hl_reg[15] == alu_b16[15]) && (res16[15] != hl_reg[15])) :
               ((hl_reg[15] != alu_b16[15]) && (res16[15] != hl_reg[15]));
            flag_next[`FOD_FLAG_SUB]   = (alu_op == `FOD_OP_SBC16);
            flag_next[`FOD_FLAG_CARRY] = wide16[16];
         end

         // Flag load and unused codes are settled below
         default: ;
      endcase

      // Sign and zero follow the result except for rotates and flag loads
      if (alu_op != `FOD_OP_RLCA && alu_op != `FOD_OP_RRCA && alu_op != `FOD_OP_LOADF) begin
         flag_next[`FOD_FLAG_SIGN] = res8[7];
         flag_next[`FOD_FLAG_ZERO] = (alu_op == `FOD_OP_ADD16 ||
            alu_op == `FOD_OP_SBC16) ? (res16 == 16'h0000) : (res8 == 8'h00);
      end
      // A flag load overwrites every bit, the two unused ones included
      if (alu_op == `FOD_OP_LOADF)
         flag_next = alu_b;
   end

   // I/O address by form. The two internal forms force the upper byte
   // to zero so that on-chip ports decode from the low lines only.
   // The pair form puts B, the high half of BC, on the low lines.
   reg  [15:0] io_next;
   always @* begin
      case (wb_dat_i[1:0])
         `FOD_IO_IMM_ACC: io_next = {acc_reg, byte_lo};
         `FOD_IO_BC:      io_next = {bc_reg[7:0], bc_reg[15:8]};
         `FOD_IO_IMM_INT: io_next = {`FOD_ZERO_BYTE, byte_lo};
         default:         io_next = {`FOD_ZERO_BYTE, bc_reg[7:0]};
      endcase
   end

   // Register writes, ALU commands and I/O cycle. A new I/O command
   // restarts the hold count; its write comes last, so it wins over the
   // release of an earlier strobe in the same cycle.
   always @(posedge clk) begin
      if (sys_rst) begin
         // Every register starts cleared and the strobe idles high
         status_flags_reg    <= `FOD_FLAG_RESET;
         acc_reg             <= 8'h00;
         bc_reg              <= 16'h0000;
         de_reg              <= 16'h0000;
         hl_reg              <= 16'h0000;
         index_reg_first     <= 16'h0000;
         index_reg_second    <= 16'h0000;
         sp_reg              <= 16'h0000;
         pc_reg              <= 16'h0000;
         alu_res_reg         <= 16'h0000;
         op_addr_reg         <= 16'h0000;
         operand_reg         <= 16'h0000;
         io_cnt_reg          <= 8'h00;
         io_addr             <= 16'h0000;
         io_request_strobe_n <= 1'b1;
      end else begin
         // Hold counter: the strobe rises on the edge that takes the count
         // from one to zero, giving IO_HOLD low cycles in all
         if (io_cnt_reg != 8'h00) begin
            io_cnt_reg <= io_cnt_reg - 8'h01;
            if (io_cnt_reg == 8'h01)
               io_request_strobe_n <= 1'b1;
         end

         // Loads and commands act only on a write of byte lane 0
         if (bus_wr) begin
            case (wb_adr_i)
               // Plain register loads
               `FOD_ADR_FLAGS: status_flags_reg <= wdat[7:0];
               `FOD_ADR_REGA:  acc_reg          <= wdat[7:0];
               `FOD_ADR_REGBC: bc_reg           <= wdat;
               `FOD_ADR_REGDE: de_reg           <= wdat;
               `FOD_ADR_REGHL: hl_reg           <= wdat;
               `FOD_ADR_REGIX: index_reg_first  <= wdat;
               `FOD_ADR_REGIY: index_reg_second <= wdat;
               `FOD_ADR_REGSP: sp_reg           <= wdat;
               `FOD_ADR_REGPC: pc_reg           <= wdat;
               // ALU command: flags and result only, the accumulator is kept
               `FOD_ADR_ALU: begin
                  status_flags_reg <= flag_next;
                  alu_res_reg      <= (alu_op == `FOD_OP_ADD16 || alu_op == `FOD_OP_SBC16)
                                      ? res16 : {8'h00, res8};
               end
               `FOD_ADR_SEL: begin
                  op_addr_reg <= addr_next;
                  // Immediate mode hands back the instruction bytes
                  if (sel_mode == `FOD_AM_IMMEDIATE)
                     operand_reg <= {byte_hi, byte_lo};
                  else
                     operand_reg <= {half_val, byte_val};
               end
               // Start an I/O request with the formed address
               `FOD_ADR_IO: begin
                  io_addr             <= io_next;
                  io_request_strobe_n <= 1'b0;
                  io_cnt_reg          <= IO_HOLD[7:0];
               end
               // Other indexes, read-only ones included, change nothing
               default: ;
            endcase
         end
      end
   end

   // Wishbone ack: follows a taken request by one cycle and lasts one
   // cycle, so the master sees one wait state
   always @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Read data is registered on the taking edge and so shows the state
   // before any write of the same access. The ALU and select command indexes
   // and unmapped ones read as zero; the I/O index reads io_addr with the strobe level at bit 16.
   always @(posedge clk) begin
      if (sys_rst) begin
         wb_dat_o <= 32'h00000000;
      end else begin
         case (wb_adr_i)
            `FOD_ADR_FLAGS:   wb_dat_o <= {24'h000000, status_flags_reg};
            `FOD_ADR_REGA:    wb_dat_o <= {24'h000000, acc_reg};
            `FOD_ADR_REGBC:   wb_dat_o <= {16'h0000, bc_reg};
            `FOD_ADR_REGDE:   wb_dat_o <= {16'h0000, de_reg};
            `FOD_ADR_REGHL:   wb_dat_o <= {16'h0000, hl_reg};
            `FOD_ADR_REGIX:   wb_dat_o <= {16'h0000, index_reg_first};
            `FOD_ADR_REGIY:   wb_dat_o <= {16'h0000, index_reg_second};
            `FOD_ADR_REGSP:   wb_dat_o <= {16'h0000, sp_reg};
            `FOD_ADR_REGPC:   wb_dat_o <= {16'h0000, pc_reg};
            `FOD_ADR_ALURES:  wb_dat_o <= {16'h0000, alu_res_reg};
            `FOD_ADR_ADDR:    wb_dat_o <= {16'h0000, op_addr_reg};
            `FOD_ADR_IO:      wb_dat_o <= {15'h0000, io_request_strobe_n, io_addr};
            `FOD_ADR_OPERAND: wb_dat_o <= {16'h0000, operand_reg};
            default:          wb_dat_o <= 32'h00000000;
         endcase
      end
   end

endmodule // fod_flags_decode

// ===== bench/fod_flags_decode_props.sv
// Assertion checker for the flag and operand decode block
`timescale 1ns/10ps
module fod_flags_decode_props #(
   parameter IO_HOLD = 4
) (
   input wire        clk,
   input wire        sys_rst,
   input wire [3:0]  wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire        wb_we_i,
   input wire [3:0]  wb_sel_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire [15:0] io_addr,
   input wire        io_request_strobe_n
);
   reg  [7:0] lo_cnt_reg;
   reg  [7:0] op_byte_reg;
   wire       take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       io_go = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0] &
                      (wb_adr_i == 4'hD) & io_request_strobe_n;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Length of the current strobe-low run and the last port byte offered
   always @(posedge clk) begin
      op_byte_reg <= wb_dat_i[23:16];
      if (sys_rst || io_request_strobe_n)
         lo_cnt_reg <= 8'h00;
      else
         lo_cnt_reg <= lo_cnt_reg + 8'h01;
   end

   a_ack_follows: assert property (take |=> wb_ack_o) else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_strobe_start: assert property (io_go |=> !io_request_strobe_n)
      else $error("io strobe did not start");
   a_strobe_len: assert property ($rose(io_request_strobe_n) |-> lo_cnt_reg == IO_HOLD)
      else $error("io strobe length wrong");
   a_addr_held: assert property (
      !io_request_strobe_n && $past(!io_request_strobe_n) |-> $stable(io_addr))
      else $error("io address moved");
   a_int_imm: assert property (io_go && wb_dat_i[1:0] == 2'h2 |=>
      io_addr == {8'h00, op_byte_reg}) else $error("internal port address wrong");
   a_int_reg: assert property (io_go && wb_dat_i[1:0] == 2'h3 |=>
      io_addr[15:8] == 8'h00) else $error("internal port upper byte not zero");
   a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 4'hF |=>
      wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
endmodule // fod_flags_decode_props

// ===== bench/fod_io_device.sv
// Passive I/O device model that latches the address of each request
`timescale 1ns/10ps
module fod_io_device (
   input  wire        clk,
   input  wire [15:0] io_addr,
   input  wire        io_request_strobe_n,
   output reg  [15:0] seen_addr,
   output reg  [7:0]  seen_count
);
   reg low_reg;
   initial begin
      seen_addr = 16'h0000;
      seen_count = 8'h00;
      low_reg = 1'b0;
   end
   // Latch on the first low cycle, count a request when the strobe ends
   always @(posedge clk) begin
      low_reg <= !io_request_strobe_n;
      if (!io_request_strobe_n && !low_reg)
         seen_addr <= io_addr;
      if (io_request_strobe_n && low_reg)
         seen_count <= seen_count + 8'h01;
   end
endmodule // fod_io_device

// ===== bench/test_fod_flags_decode.sv
// Self-checking bench for the flag and operand decode block
`timescale 1ns/10ps
module test_fod_flags_decode;
   reg  clk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   reg  [3:0]  wb_adr_i = 4'h0;
   reg  [3:0]  wb_sel_i = 4'hF;
   reg  [31:0] wb_dat_i = 32'h0000_0000;
   reg  [31:0] rd;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o, io_request_strobe_n;
   wire [15:0] io_addr, seen_addr;
   wire [7:0]  seen_count;
   integer     miscompares = 0, comparisons = 0, cycles = 0, g;
   localparam [127:0] RV = {16'h6000,16'h5000,16'h2345,16'h1000,16'h4151,16'hD1E1,16'hB1C1,16'h00AA};
   localparam [63:0]  BV = {8'hAA,8'h00,8'h51,8'h41,8'hE1,8'hD1,8'hC1,8'hB1};

   fod_flags_decode #(.IO_HOLD(4)) fod_flags_decode_i (.clk(clk), .sys_rst(sys_rst),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .io_addr(io_addr), .io_request_strobe_n(io_request_strobe_n));
   fod_io_device fod_io_device_i (.clk(clk), .io_addr(io_addr),
      .io_request_strobe_n(io_request_strobe_n), .seen_addr(seen_addr), .seen_count(seen_count));

   initial forever #5 clk = ~clk;
   // Cut a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         wrap_up;
      end
   end

   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // One classic bus cycle, held until ack is sampled
   task wb(input [3:0] adr, input we, input [31:0] dat);
      begin
         @(posedge clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= we;
         wb_adr_i <= adr;
         wb_dat_i <= dat;
         @(posedge clk);
         while (wb_ack_o !== 1'b1)
            @(posedge clk);
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask
   // Load A and HL, run one operation, check result (not for CP or flag load) and the masked flags
   task alu(input [15:0] a, input [3:0] op, input [15:0] b, input [15:0] res, input [7:0] fl);
      reg [7:0] m;
      begin
         m = (op >= 4'hC) ? 8'hC7 : (op >= 4'hA) ? 8'h01 : (op >= 4'h7) ? 8'hD4 : 8'hD7;
         if (op == 4'hE)
            m = 8'hFF;
         wb(4'h1, 1'b1, {24'h0, a[7:0]});
         wb(4'h4, 1'b1, {16'h0, a});
         wb(4'h9, 1'b1, {b, 4'h0, b[7:0], op});
         wb(4'hA, 1'b0, 32'h0);
         if (op != 4'h4 && op != 4'hE)
            chk("result", {16'h0, res}, rd);
         wb(4'h0, 1'b0, 32'h0);
         chk("flags", {24'h0, fl & m}, rd & {24'h0, m});
      end
   endtask
   task sel(input [7:0] hi, lo, input [2:0] md, input h, input [1:0] t, p, input [2:0] bs,
            input [15:0] ea, ev);
      begin
         wb(4'hB, 1'b1, {hi, lo, 5'h00, md, h, t, p, bs});
         wb(4'hC, 1'b0, 32'h0);
         chk("address", {16'h0, ea}, rd);
         wb(4'hE, 1'b0, 32'h0);
         chk("value", {16'h0, ev}, rd);
      end
   endtask
   task io(input [1:0] f, input [7:0] b, input [15:0] ea);
      reg [7:0] n0;
      begin
         n0 = seen_count;
         wb(4'hD, 1'b1, {8'h00, b, 14'h0000, f});
         while (seen_count == n0)
            @(posedge clk);
         chk("io addr", {16'h0, ea}, {16'h0, seen_addr});
      end
   endtask
   task t_reset;
      begin
         wb(4'h0, 1'b0, 32'h0);
         chk("flags", 32'h0, rd);
         wb(4'hF, 1'b0, 32'h0);
         chk("unmapped", 32'h0, rd);
      end
   endtask
   task t_alu;
      begin
         alu(16'h0000, 4'hE, 16'h00FF, 16'h0000, 8'hFF);
         alu(16'h007F, 4'h0, 16'h0001, 16'h0080, 8'h94);
         alu(16'h00FF, 4'h0, 16'h0001, 16'h0000, 8'h51);
         alu(16'h0080, 4'h2, 16'h0001, 16'h007F, 8'h16);
         alu(16'h0000, 4'h2, 16'h0001, 16'h00FF, 8'h93);
         alu(16'h0005, 4'h4, 16'h0005, 16'h0000, 8'h42);
         alu(16'h000F, 4'h5, 16'h0000, 16'h0010, 8'h10);
         alu(16'h0080, 4'h6, 16'h0000, 16'h007F, 8'h16);
         alu(16'h00F0, 4'h7, 16'h003C, 16'h0030, 8'h14);
         alu(16'h0001, 4'h9, 16'h0003, 16'h0002, 8'h00);
         alu(16'h0000, 4'h8, 16'h0000, 16'h0000, 8'h44);
         alu(16'h0081, 4'hA, 16'h0000, 16'h0003, 8'h01);
         alu(16'h000F, 4'h1, 16'h0000, 16'h0010, 8'h10);
         alu(16'h0001, 4'hB, 16'h0000, 16'h0080, 8'h01);
         alu(16'h0000, 4'h3, 16'h0000, 16'h00FF, 8'h93);
         alu(16'h7FFF, 4'hC, 16'h0001, 16'h8000, 8'h84);
         alu(16'h8000, 4'hD, 16'h0001, 16'h7FFF, 8'h06);
      end
   endtask
   task t_sel;
      begin
         for (g = 1; g <= 8; g = g + 1)
            wb(g[3:0], 1'b1, {16'h0, RV[(g-1)*16 +: 16]});
         for (g = 0; g < 8; g = g + 1)
            sel(0, 0, 3'h0, 0, 2'h0, 2'h0, g[2:0], 16'hB1C1, {8'hC1, BV[g*8 +: 8]});
         sel(0, 0, 3'h0, 1, 2'h0, 2'h1, 0, 16'hD1E1, 16'hD1B1);
         sel(0, 0, 3'h0, 1, 2'h0, 2'h2, 0, 16'h4151, 16'h41B1);
         sel(8'h12, 8'h34, 3'h2, 1, 2'h1, 2'h2, 0, 16'h1234, 16'h10B1);
         sel(8'h56, 8'h78, 3'h2, 0, 2'h2, 2'h2, 0, 16'h5678, 16'h45B1);
         sel(0, 0, 3'h0, 1, 2'h0, 2'h3, 0, 16'h4151, 16'h50B1);
         sel(0, 0, 3'h0, 1, 2'h3, 2'h3, 0, 16'h4151, 16'hAAB1);
         sel(0, 8'hFE, 3'h1, 0, 2'h0, 2'h0, 0, 16'h0FFE, 16'hC1B1);
         sel(0, 8'h05, 3'h1, 0, 2'h2, 2'h0, 0, 16'h234A, 16'hC1B1);
         sel(0, 8'h80, 3'h4, 0, 2'h0, 2'h0, 0, 16'h5F80, 16'hC1B1);
         sel(8'hAB, 8'hCD, 3'h3, 0, 2'h0, 2'h0, 0, 16'h5F80, 16'hABCD);
      end
   endtask
   task t_io;
      begin
         io(2'h0, 8'h3C, 16'hAA3C);
         io(2'h1, 8'h00, 16'hC1B1);
         io(2'h2, 8'h7E, 16'h007E);
         io(2'h3, 8'h00, 16'h00C1);
         wb(4'hD, 1'b0, 32'h0);
         chk("status", 32'h0001_00C1, rd);
      end
   endtask
   task t_rereset;
      begin
         alu(16'h0000, 4'hE, 16'h00FF, 16'h0000, 8'hFF);
         sys_rst <= 1'b1;
         repeat (2) @(posedge clk);
         sys_rst <= 1'b0;
         wb(4'h0, 1'b0, 32'h0);
         chk("flags", 32'h0, rd & 32'h0000_00D7);
      end
   endtask

   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_alu;
      t_sel;
      t_io;
      t_rereset;
      wrap_up;
   end
endmodule // test_fod_flags_decode

bind fod_flags_decode fod_flags_decode_props #(.IO_HOLD(IO_HOLD)) fod_flags_decode_props_i (
   .clk(clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
   .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .io_addr(io_addr), .io_request_strobe_n(io_request_strobe_n));
